// ---- core/prs_sequencer.sv ----
/*
 rail sequencer for two factory presets: pin and power-good driven enables,
 voltage selection, general outputs and an apb register file.
 assumes control pins and power-good levels are asynchronous, apb on i_mclk.
*/
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "prs_regs.svh"
module prs_sequencer #(
    parameter int VARIANT = 0,
    parameter int MEM_DELAY_CYC = `PRS_MEM_DELAY_US * `PRS_CLK_MHZ
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // pins and analog status
    input wire logic [5:0] i_ctl,
    input wire prs_pkg::prs_rails_t i_pg,
    // rail controls
    output prs_pkg::prs_rails_t o_rail_en,
    output prs_pkg::prs_rails_t o_dischg_en,
    output prs_pkg::prs_vcode_t o_step_down_reg_two_code,
    output prs_pkg::prs_vcode_t o_step_down_reg_three_code,
    output prs_pkg::prs_vcode_t o_step_down_reg_four_code,
    output prs_pkg::prs_vcode_t o_step_down_reg_six_code,
    output prs_pkg::prs_vcode_t o_aux1_code,
    output logic o_vtt_ilim_high,
    output logic o_vtt_fault_mask,
    // general outputs
    output logic o_general_output_one_out,
    output logic o_general_output_one_oe,
    output logic o_general_output_two_out,
    output logic o_general_output_two_oe
);
    import prs_pkg::*;

    localparam bit VAR_A = (VARIANT == 0);

    logic [5:0] c;
    prs_rails_t p;
    prs_rails_t en_reg;
    prs_rails_t go;
    prs_rails_t hold;
    prs_b6_state_t b6_state_reg;
    prs_b6_state_t b6_state_next;
    logic b6_gate;
    logic b6_delay_done;
    logic [31:0] ctrl_reg;
    logic [31:0] step_down_reg_three_reg;
    logic [31:0] shared1_reg;
    logic [31:0] shared2_reg;
    logic [31:0] rdata_next;
    logic addr_ok;
    logic wr_en;

    prs_sync #(
        .W(6)
    ) u_ctl_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_async(i_ctl),
        .o_sync(c)
    );

    prs_sync #(
        .W(12)
    ) u_pg_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_async(i_pg),
        .o_sync(p)
    );

    // apb: zero wait states, register writes take effect in the access cycle
    assign o_pready = 1'b1;
    assign wr_en = i_psel && i_penable && i_pwrite && addr_ok;
    assign o_pslverr = i_psel && i_penable && !addr_ok;

    always_comb begin
        addr_ok = 1'b1;
        rdata_next = 32'h0000_0000;
        case (i_paddr)
            `PRS_OFF_CTRL: rdata_next = ctrl_reg;
            `PRS_OFF_STEP_DOWN_REG_THREE: rdata_next = step_down_reg_three_reg;
            `PRS_OFF_SHARED1: rdata_next = shared1_reg;
            `PRS_OFF_SHARED2: rdata_next = shared2_reg;
            `PRS_OFF_STATUS: rdata_next = {8'h00, p, en_reg};
            `PRS_OFF_PINS: rdata_next = {26'h000_0000, c};
            default: addr_ok = 1'b0;
        endcase
    end

    // read data captured in the setup cycle, stable through the access
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= rdata_next;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= 32'h0000_0000;
        end else if (wr_en && i_paddr == `PRS_OFF_CTRL) begin
            ctrl_reg <= {27'h000_0000, i_pwdata[4:0]};
        end
    end

    // normal code [8:0], sleep code [17:9], sleep select [18]
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            step_down_reg_three_reg <= {13'h0000, 1'b1, `PRS_V_1V2, `PRS_V_1V2};
        end else if (wr_en && i_paddr == `PRS_OFF_STEP_DOWN_REG_THREE) begin
            step_down_reg_three_reg <= {13'h0000, i_pwdata[18:0]};
        end
    end

    // first shared set: aux one voltage code in both presets
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shared1_reg <= {23'h00_0000, VAR_A ? `PRS_V_2V5 : `PRS_V_1V8};
        end else if (wr_en && i_paddr == `PRS_OFF_SHARED1) begin
            shared1_reg <= {23'h00_0000, i_pwdata[8:0]};
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shared2_reg <= 32'h0000_0000;
        end else if (wr_en && i_paddr == `PRS_OFF_SHARED2) begin
            shared2_reg <= {31'h0000_0000, i_pwdata[0]};
        end
    end

    // step-down six gate; delay runs only in the first preset
    always_comb begin
        if (VAR_A) begin
            b6_gate = c[`PRS_C1] && c[`PRS_C3] && en_reg[`PRS_R_B5];
        end else begin
            b6_gate = c[`PRS_C1] && c[`PRS_C6] && p[`PRS_R_B3];
        end
    end

    prs_delay #(
        .CYCLES(MEM_DELAY_CYC),
        .CW(17)
    ) u_mem_delay (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_run(b6_state_reg == b6_wait),
        .o_done(b6_delay_done)
    );

    always_comb begin
        b6_state_next = b6_state_reg;
        case (b6_state_reg)
            b6_off: begin
                if (b6_gate) begin
                    b6_state_next = b6_wait;
                end
            end
            b6_wait: begin
                if (!b6_gate) begin
                    b6_state_next = b6_off;
                end else if (b6_delay_done || !VAR_A) begin
                    b6_state_next = b6_on;
                end
            end
            b6_on: begin
                // stays up until memory rails fed by it are down
                if (!b6_gate && !p[`PRS_R_A1] && !p[`PRS_R_VTT]) begin
                    b6_state_next = b6_off;
                end
            end
            default: b6_state_next = b6_off;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            b6_state_reg <= b6_off;
        end else begin
            b6_state_reg <= b6_state_next;
        end
    end

    // start conditions and reverse-order holds
    always_comb begin
        go = '0;
        hold = '0;
        go[`PRS_R_B6] = (b6_state_next == b6_on);
        go[`PRS_R_A2] = ctrl_reg[`PRS_CTRL_AUX2];
        go[`PRS_R_A3] = ctrl_reg[`PRS_CTRL_AUX3];
        go[`PRS_R_LOAD_SWITCH_B_FIRST] = ctrl_reg[`PRS_CTRL_LOAD_SWITCH_B_FIRST];
        if (VAR_A) begin
            go[`PRS_R_B5] = c[`PRS_C3];
            go[`PRS_R_B2] = c[`PRS_C3] && c[`PRS_C4];
            go[`PRS_R_B3] = c[`PRS_C3] && p[`PRS_R_B2];
            go[`PRS_R_B4] = c[`PRS_C3] && p[`PRS_R_B3];
            go[`PRS_R_A1] = c[`PRS_C1] && c[`PRS_C3] && en_reg[`PRS_R_B6]
                && p[`PRS_R_B6];
            go[`PRS_R_VTT] = c[`PRS_C1] && c[`PRS_C3] && c[`PRS_C5]
                && p[`PRS_R_B6];
            go[`PRS_R_SWA] = ctrl_reg[`PRS_CTRL_SWA];
            go[`PRS_R_LOAD_SWITCH_B_SECOND] = shared2_reg[`PRS_SH2_EN_BIT];
            hold[`PRS_R_B5] = p[`PRS_R_B6] || p[`PRS_R_B2];
            hold[`PRS_R_B2] = p[`PRS_R_B3];
            hold[`PRS_R_B3] = p[`PRS_R_B4];
        end else begin
            go[`PRS_R_B5] = c[`PRS_C1];
            go[`PRS_R_B4] = c[`PRS_C1] && p[`PRS_R_B5];
            go[`PRS_R_B2] = c[`PRS_C1] && c[`PRS_C6];
            go[`PRS_R_B3] = c[`PRS_C1] && c[`PRS_C6] && p[`PRS_R_B2];
            go[`PRS_R_A1] = c[`PRS_C1] && c[`PRS_C6] && p[`PRS_R_B6];
            go[`PRS_R_VTT] = c[`PRS_C6] && p[`PRS_R_B6];
            go[`PRS_R_SWA] = c[`PRS_C5];
            // merged pair: second set has no effect
            go[`PRS_R_LOAD_SWITCH_B_SECOND] = ctrl_reg[`PRS_CTRL_LOAD_SWITCH_B_FIRST];
            hold[`PRS_R_B5] = p[`PRS_R_B4];
            hold[`PRS_R_B4] = p[`PRS_R_B2];
            hold[`PRS_R_B2] = p[`PRS_R_B3];
            hold[`PRS_R_B3] = p[`PRS_R_B6];
        end
    end

    // a dropped start keeps a rail up until its dependant reports down
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_reg <= '0;
        end else begin
            en_reg <= go | (en_reg & hold);
        end
    end

    assign o_rail_en = en_reg;
    assign o_dischg_en = ~en_reg;

    // voltage selection from pins and registers
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_step_down_reg_two_code <= `PRS_V_0V85;
            o_step_down_reg_three_code <= `PRS_V_1V2;
            o_step_down_reg_four_code <= VAR_A ? `PRS_V_0V9 : `PRS_V_3V3;
            o_step_down_reg_six_code <= `PRS_V_1V2;
            o_aux1_code <= VAR_A ? `PRS_V_2V5 : `PRS_V_1V8;
        end else begin
            o_aux1_code <= shared1_reg[8:0];
            if (step_down_reg_three_reg[`PRS_B3_SLP_BIT] && !c[`PRS_C6]) begin
                o_step_down_reg_three_code <= step_down_reg_three_reg[17:9];
            end else begin
                o_step_down_reg_three_code <= step_down_reg_three_reg[8:0];
            end
            if (VAR_A) begin
                o_step_down_reg_two_code <= c[`PRS_C6] ? `PRS_V_0V9 : `PRS_V_0V85;
                o_step_down_reg_four_code <= `PRS_V_0V9;
                o_step_down_reg_six_code <= c[`PRS_C2] ? `PRS_V_1V35 : `PRS_V_1V2;
            end else begin
                o_step_down_reg_two_code <= `PRS_V_0V85;
                o_step_down_reg_four_code <= c[`PRS_C6] ? `PRS_V_3V3 : `PRS_V_0V;
                if (!c[`PRS_C3]) begin
                    o_step_down_reg_six_code <= `PRS_V_1V1;
                end else begin
                    o_step_down_reg_six_code <= c[`PRS_C2] ? `PRS_V_1V5 : `PRS_V_1V2;
                end
            end
        end
    end

    // termination limit and fault mask are fixed by preset
    assign o_vtt_ilim_high = VAR_A;
    assign o_vtt_fault_mask = !VAR_A;

    // output one: push-pull in the first preset, open drain in the second
    always_comb begin
        if (VAR_A) begin
            o_general_output_one_out = p[`PRS_R_B5];
            o_general_output_one_oe = 1'b1;
            o_general_output_two_out = 1'b0;
            o_general_output_two_oe = !ctrl_reg[`PRS_CTRL_GENERAL_OUTPUT_TWO];
        end else begin
            o_general_output_one_out = 1'b0;
            o_general_output_one_oe = !p[`PRS_R_B4];
            o_general_output_two_out = 1'b0;
            o_general_output_two_oe = !p[`PRS_R_B6];
        end
    end

    // helper: cycles spent waiting with the gate up
    logic [16:0] chk_wait_cnt;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chk_wait_cnt <= '0;
        end else if (b6_state_reg != b6_wait) begin
            chk_wait_cnt <= '0;
        end else begin
            chk_wait_cnt <= chk_wait_cnt + 17'h00001;
        end
    end

    chk_b6_delay: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        VAR_A && $rose(en_reg[`PRS_R_B6])
            |-> $past(chk_wait_cnt) >= 17'(MEM_DELAY_CYC - 1))
        else $error("step-down six enabled before delay");
    chk_aux1_after_pg: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(en_reg[`PRS_R_A1]) |-> $past(p[`PRS_R_B6]) && $past(en_reg[`PRS_R_B6]))
        else $error("aux one enabled without step-down six good");
    chk_vtt_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        VAR_A && $rose(en_reg[`PRS_R_VTT])
            |-> $past(c[`PRS_C5] && c[`PRS_C1] && c[`PRS_C3] && p[`PRS_R_B6]))
        else $error("termination enabled without its pins");
    chk_mem_vsel: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        VAR_A && $stable(c) ##1 1'b1
            |-> o_step_down_reg_six_code == ($past(c[`PRS_C2]) ? `PRS_V_1V35 : `PRS_V_1V2))
        else $error("memory voltage does not follow pin two");
    chk_bram_vsel: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        VAR_A && !c[`PRS_C6] ##1 1'b1 |-> o_step_down_reg_two_code == `PRS_V_0V85)
        else $error("block memory voltage does not follow pin six");
    chk_aux_sw_only: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ##1 1'b1 |-> en_reg[`PRS_R_A2] == $past(ctrl_reg[`PRS_CTRL_AUX2])
            && en_reg[`PRS_R_A3] == $past(ctrl_reg[`PRS_CTRL_AUX3]))
        else $error("aux two or three moved without a write");
    chk_swb_merged: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !VAR_A |-> en_reg[`PRS_R_LOAD_SWITCH_B_SECOND] == en_reg[`PRS_R_LOAD_SWITCH_B_FIRST])
        else $error("merged b switches differ");
    chk_dischg_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (o_rail_en & o_dischg_en) == 12'h000)
        else $error("discharge on while rail enabled");
    chk_b3_sleep: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        step_down_reg_three_reg[`PRS_B3_SLP_BIT] && !c[`PRS_C6] ##1 1'b1
            |-> o_step_down_reg_three_code == $past(step_down_reg_three_reg[17:9]))
        else $error("step-down three ignores sleep code");
endmodule

// ---- core/prs_regs.svh ----
/*
 rail sequencer constants: register offsets, field positions, reset values,
 rail indices and timing counts. assumes a 50 MHz sequencer clock.
*/
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH

`define PRS_CLK_MHZ 50
`define PRS_MEM_DELAY_US 2000

`define PRS_OFF_CTRL 8'h00
`define PRS_OFF_STEP_DOWN_REG_THREE 8'h04
`define PRS_OFF_SHARED1 8'h08
`define PRS_OFF_SHARED2 8'h0C
`define PRS_OFF_STATUS 8'h10
`define PRS_OFF_PINS 8'h14

`define PRS_CTRL_AUX2 0
`define PRS_CTRL_AUX3 1
`define PRS_CTRL_GENERAL_OUTPUT_TWO 2
`define PRS_CTRL_SWA 3
`define PRS_CTRL_LOAD_SWITCH_B_FIRST 4
`define PRS_B3_SLP_BIT 18
`define PRS_SH2_EN_BIT 0

`define PRS_R_B2 0
`define PRS_R_B3 1
`define PRS_R_B4 2
`define PRS_R_B5 3
`define PRS_R_B6 4
`define PRS_R_A1 5
`define PRS_R_A2 6
`define PRS_R_A3 7
`define PRS_R_VTT 8
`define PRS_R_SWA 9
`define PRS_R_LOAD_SWITCH_B_FIRST 10
`define PRS_R_LOAD_SWITCH_B_SECOND 11

`define PRS_C1 0
`define PRS_C2 1
`define PRS_C3 2
`define PRS_C4 3
`define PRS_C5 4
`define PRS_C6 5

// voltage codes in 10 mV units
`define PRS_V_0V85 9'h055
`define PRS_V_0V9 9'h05A
`define PRS_V_1V1 9'h06E
`define PRS_V_1V2 9'h078
`define PRS_V_1V35 9'h087
`define PRS_V_1V5 9'h096
`define PRS_V_1V8 9'h0B4
`define PRS_V_2V5 9'h0FA
`define PRS_V_3V3 9'h14A
`define PRS_V_0V 9'h000

`endif

// ---- core/prs_pkg.sv ----
/*
 rail sequencer types. assumes prs_regs.svh for the numbers.
*/
package prs_pkg;
    typedef enum logic [1:0] {
        b6_off = 2'b00,
        b6_wait = 2'b01,
        b6_on = 2'b10
    } prs_b6_state_t;
    typedef logic [8:0] prs_vcode_t;
    typedef logic [11:0] prs_rails_t;
endpackage

// ---- core/prs_sync.sv ----
/*
 two-flop synchroniser for a group of pins.
 assumes every bit is an independent level.
*/
`timescale 1ns/100ps
module prs_sync #(
    parameter int W = 6
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= '0;
            o_sync <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule

// ---- core/prs_delay.sv ----
/*
 restartable delay: o_done rises CYCLES clocks after i_run rises and
 stays high while i_run holds. assumes i_run is synchronous.
*/
`timescale 1ns/100ps
module prs_delay #(
    parameter int CYCLES = 100000,
    parameter int CW = 17
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // control
    input wire logic i_run,
    output logic o_done
);
    logic [CW-1:0] cnt_reg;

    // restarts whenever the run level drops
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= '0;
        end else if (!i_run) begin
            cnt_reg <= '0;
        end else if (!o_done) begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end

    assign o_done = (cnt_reg >= CW'(CYCLES));
endmodule

// ---- dv/prs_board_model.sv ----
/*
 board model for the rail sequencer: per-rail power good after a settling
 delay, pull-ups on both general outputs, and general output one looped back
 into one control pin. assumes rail enables are levels on i_mclk.
*/
`timescale 1ns/100ps
module prs_board_model #(
    parameter int LOOP_BIT = 3,
    parameter int PG_DELAY = 30
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // from the bench
    input wire logic [5:0] i_pins,
    input wire logic i_slow,
    // from the sequencer
    input wire prs_pkg::prs_rails_t i_rail_en,
    input wire logic i_general_output_one_out,
    input wire logic i_general_output_one_oe,
    input wire logic i_general_output_two_out,
    input wire logic i_general_output_two_oe,
    // to the sequencer
    output prs_pkg::prs_rails_t o_pg,
    output logic [5:0] o_ctl,
    output logic o_general_output_one_wire,
    output logic o_general_output_two_wire
);
    import prs_pkg::*;
    int cnt [12];
    // a released output floats up through the board pull-up
    assign o_general_output_one_wire = i_general_output_one_oe ? i_general_output_one_out : 1'b1;
    assign o_general_output_two_wire = i_general_output_two_oe ? i_general_output_two_out : 1'b1;
    // the loop stands in for an external regulator whose good follows its enable
    always_comb begin
        o_ctl = i_pins;
        o_ctl[LOOP_BIT] = o_general_output_one_wire;
    end
    // good only after settling; a slow board shows whether enables wait for it
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pg <= '0;
            for (int i = 0; i < 12; i++) cnt[i] <= 0;
        end else begin
            for (int i = 0; i < 12; i++) begin
                if (!i_rail_en[i]) begin
                    cnt[i] <= 0;
                    o_pg[i] <= 1'b0;
                end else if (cnt[i] >= (i_slow ? PG_DELAY : 2)) begin
                    o_pg[i] <= 1'b1;
                end else begin
                    cnt[i] <= cnt[i] + 1;
                end
            end
        end
    end
endmodule

// ---- dv/prs_sequencer_bench.sv ----
/*
 bench for the rail sequencer: both presets side by side on one apb bus,
 each with its own board model. assumes the apb slave answers without waits.
*/
`timescale 1ns/100ps
`include "prs_regs.svh"
module prs_sequencer_bench;
    import prs_pkg::*;
    localparam int MEM = 20;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic slow = 1'b1;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, prdata1;
    logic pready, pready1, pslverr, pslverr1, ilim0, mask0, ilim1, mask1;
    logic [5:0] pins0 = '0;
    logic [5:0] pins1 = '0;
    logic [5:0] ctl0, control_input_one;
    prs_rails_t pg0, pg1, en0, en1, dis0, dis1;
    prs_vcode_t b2, b3, b6, a1, b4v1, b6v1;
    logic g1o0, g1e0, g2o0, g2e0, g1o1, g1e1, g2o1, g2e1, w10, w20, w11, w21;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;

    prs_sequencer #(.VARIANT(0), .MEM_DELAY_CYC(MEM)) u_dut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_ctl(ctl0), .i_pg(pg0),
        .o_rail_en(en0), .o_dischg_en(dis0), .o_step_down_reg_two_code(b2), .o_step_down_reg_three_code(b3),
        .o_step_down_reg_four_code(), .o_step_down_reg_six_code(b6), .o_aux1_code(a1), .o_vtt_ilim_high(ilim0),
        .o_vtt_fault_mask(mask0), .o_general_output_one_out(g1o0), .o_general_output_one_oe(g1e0),
        .o_general_output_two_out(g2o0), .o_general_output_two_oe(g2e0));
    prs_sequencer #(.VARIANT(1), .MEM_DELAY_CYC(MEM)) u_dut_v1 (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata1),
        .o_pready(pready1), .o_pslverr(pslverr1), .i_ctl(control_input_one), .i_pg(pg1),
        .o_rail_en(en1), .o_dischg_en(dis1), .o_step_down_reg_two_code(), .o_step_down_reg_three_code(),
        .o_step_down_reg_four_code(b4v1), .o_step_down_reg_six_code(b6v1), .o_aux1_code(), .o_vtt_ilim_high(ilim1),
        .o_vtt_fault_mask(mask1), .o_general_output_one_out(g1o1), .o_general_output_one_oe(g1e1),
        .o_general_output_two_out(g2o1), .o_general_output_two_oe(g2e1));
    prs_board_model #(.LOOP_BIT(`PRS_C4), .PG_DELAY(30)) u_board0 (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pins(pins0), .i_slow(slow), .i_rail_en(en0),
        .i_general_output_one_out(g1o0), .i_general_output_one_oe(g1e0), .i_general_output_two_out(g2o0), .i_general_output_two_oe(g2e0),
        .o_pg(pg0), .o_ctl(ctl0), .o_general_output_one_wire(w10), .o_general_output_two_wire(w20));
    prs_board_model #(.LOOP_BIT(`PRS_C6), .PG_DELAY(30)) u_board1 (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pins(pins1), .i_slow(slow), .i_rail_en(en1),
        .i_general_output_one_out(g1o1), .i_general_output_one_oe(g1e1), .i_general_output_two_out(g2o1), .i_general_output_two_oe(g2e1),
        .o_pg(pg1), .o_ctl(control_input_one), .o_general_output_one_wire(w11), .o_general_output_two_wire(w21));

    initial begin
        forever #10 i_mclk = ~i_mclk;
    end

    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("unexpected at %0t: run did not finish", $time);
            test_done;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge i_mclk);
    endtask

    // request held until pready is sampled high; read data taken at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge i_mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        penable <= 1'b1;
        // only the bench timeout ends a wait for the answer
        do begin
            @(posedge i_mclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic wait_en(input logic v1, input int idx, input logic val, input int lim,
                           output int n);
        n = 0;
        while ((v1 ? en1[idx] : en0[idx]) !== val && n < lim) begin
            @(posedge i_mclk);
            n++;
        end
        check(32'(v1 ? en1[idx] : en0[idx]), 32'(val), "rail enable");
    endtask

    task automatic t_reset;
        logic [31:0] q;
        logic e;
        check(32'(en0), 32'h0, "enables");
        check(32'(dis0), 32'hFFF, "discharge");
        check(32'(b2), 32'h055, "block memory code");
        check(32'(b6), 32'h078, "memory code");
        check(32'({ilim0, mask0, ilim1, mask1}), 32'h9, "termination setup");
        check(32'({g1e0, w20}), 32'h2, "general outputs");
        apb(1'b0, `PRS_OFF_STEP_DOWN_REG_THREE, '0, q, e);
        check(q, 32'h0004F078, "step-down three reg");
        apb(1'b0, 8'h20, '0, q, e);
        check(q, 32'h0, "unmapped data");
        check(32'(e), 32'h1, "unmapped error");
        $display("test reset done");
    endtask

    task automatic t_regs;
        logic [31:0] q;
        logic e;
        wr(`PRS_OFF_SHARED2, 32'h1);
        wr(`PRS_OFF_CTRL, 32'h7);
        idle(3);
        check(32'({en1[7:6], en0[7:6], en0[11], en1[11], w20}), 32'h7D, "reg rails");
        // rails just enabled, none settled yet on the slow board
        apb(1'b0, `PRS_OFF_STATUS, '0, q, e);
        check(q, 32'h0000_08C0, "status readback");
        wr(`PRS_OFF_SHARED1, 32'hA0);
        idle(3);
        check(32'(a1), 32'h0A0, "aux one code");
        wr(`PRS_OFF_CTRL, 32'h10);
        idle(3);
        check(32'({en1[11:10], en0[7:6], en0[10], w20}), 32'h32, "b switches");
        wr(`PRS_OFF_CTRL, 32'h0);
        wr(`PRS_OFF_SHARED2, 32'h0);
        $display("test registers done");
    endtask

    task automatic t_v0_seq;
        int n;
        @(posedge i_mclk);
        pins0 <= 6'h04;
        wait_en(1'b0, `PRS_R_B5, 1'b1, 10, n);
        wait_en(1'b0, `PRS_R_B2, 1'b1, 60, n);
        wait_en(1'b0, `PRS_R_B4, 1'b1, 120, n);
        check(32'(en0[`PRS_R_B6]), 32'h0, "six gated");
        idle(1);
        pins0 <= 6'h15;
        idle(10);
        pins0 <= 6'h14;
        idle(5);
        pins0 <= 6'h15;
        wait_en(1'b0, `PRS_R_B6, 1'b1, MEM + 8, n);
        check(32'(n >= MEM), 32'h1, "memory delay");
        check(32'({en0[`PRS_R_A1], en0[`PRS_R_VTT]}), 32'h0, "before six good");
        wait_en(1'b0, `PRS_R_A1, 1'b1, 60, n);
        wait_en(1'b0, `PRS_R_VTT, 1'b1, 5, n);
        check(32'(dis0), 32'(en0 ^ 12'hFFF), "discharge");
        idle(1);
        pins0 <= 6'h11;
        wait_en(1'b0, `PRS_R_B6, 1'b0, 200, n);
        check(32'(en0[`PRS_R_B5]), 32'h1, "five outlasts six");
        idle(1);
        pins0 <= 6'h00;
        $display("test first preset sequence done");
    endtask

    task automatic t_volt;
        logic [31:0] q;
        logic e;
        @(posedge i_mclk);
        pins0 <= 6'h22;
        idle(5);
        check(32'(b6), 32'h087, "memory high");
        check(32'(b2), 32'h05A, "block memory high");
        apb(1'b0, `PRS_OFF_PINS, '0, q, e);
        check(q, 32'h22, "pin readback");
        wr(`PRS_OFF_STEP_DOWN_REG_THREE, 32'h0004C878);
        idle(4);
        check(32'(b3), 32'h078, "three normal");
        pins0 <= 6'h00;
        idle(5);
        check(32'(b3), 32'h064, "three sleep");
        check(32'(b6), 32'h078, "memory low");
        check(32'(b2), 32'h055, "block memory low");
        $display("test voltages done");
    endtask

    task automatic t_v1;
        int n;
        @(posedge i_mclk);
        slow <= 1'b0;
        pins1 <= 6'h10;
        wait_en(1'b1, `PRS_R_SWA, 1'b1, 10, n);
        check(32'({en1[`PRS_R_B5], b4v1}), 32'h0, "before start");
        idle(1);
        pins1 <= 6'h13;
        wait_en(1'b1, `PRS_R_B5, 1'b1, 10, n);
        wait_en(1'b1, `PRS_R_B6, 1'b1, 80, n);
        wait_en(1'b1, `PRS_R_VTT, 1'b1, 20, n);
        check(32'({w11, w21}), 32'h3, "second preset outputs released");
        check(32'(b4v1), 32'h14A, "four awake");
        check(32'(b6v1), 32'h06E, "six sleep");
        idle(1);
        pins1 <= 6'h17;
        idle(5);
        check(32'(b6v1), 32'h096, "six high");
        pins1 <= 6'h15;
        idle(5);
        check(32'(b6v1), 32'h078, "six low");
        $display("test second preset done");
    endtask

    initial begin
        repeat (8) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        idle(2);
        t_reset;
        t_regs;
        t_v0_seq;
        // second reset in mid-run clears any held chain before the voltage test
        i_rst_n <= 1'b0;
        idle(3);
        i_rst_n <= 1'b1;
        idle(2);
        t_volt;
        t_v1;
        test_done;
    end
endmodule
